// *** core/aoc_pkg.sv ***
// Shared constants and types for the angle output conditioning block
package aoc_pkg;
    // ======================================
    // Register word indices (byte address = 4 * index)
    localparam logic [3:0] IX_REF = 4'h0;
    localparam logic [3:0] IX_FLO = 4'h1;
    localparam logic [3:0] IX_FHI = 4'h2;
    localparam logic [3:0] IX_PRE = 4'h3;
    localparam logic [3:0] IX_SCALE = 4'h4;
    localparam logic [3:0] IX_SHIFT = 4'h5;
    localparam logic [3:0] IX_OLO = 4'h6;
    localparam logic [3:0] IX_OHI = 4'h7;
    localparam logic [3:0] IX_CUT = 4'h8;
    localparam logic [3:0] IX_THR = 4'h9;
    localparam logic [3:0] IX_SET1 = 4'ha;
    localparam logic [3:0] IX_SET2 = 4'hb;
    localparam logic [3:0] IX_FOLD = 4'hc;
    localparam logic [3:0] IX_STAT = 4'hd;
    localparam logic [3:0] IX_OUT = 4'he;
    localparam int NCFG = 13;
    // ======================================
    // Field positions
    localparam int B_INTERP = 15;
    localparam int B_FC2 = 13;
    localparam int B_SENT = 12;
    localparam int B_OC = 8;
    localparam int B_EBAND = 7;
    localparam int B_START = 4;
    localparam int B_LATCH = 2;
    localparam int B_SHOW = 1;
    localparam int B_LOCK = 0;
    localparam int B_FOLD_EN = 0;
    localparam int B_FOLD_120 = 1;
    localparam int ST_ARMED = 5;
    // ======================================
    // Reset values, index 12 down to 0
    localparam logic [NCFG-1:0][15:0] CFG_RST = {
        16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0800,
        16'h3fff, 16'h0000, 16'h0000, 16'h0200, 16'h0000,
        16'h7fff, 16'h8000, 16'h0000};
    // ======================================
    // Scaling and codes
    localparam int GAIN_SHIFT = 11;
    localparam int QF_SHIFT = 15;
    localparam logic [15:0] FULL_SCALE = 16'h3fff;
    localparam logic [11:0] SENT_INIT = 12'hffe;
    localparam logic [11:0] SENT_ERR = 12'hffb;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] OC_SUP = 2'h1;
    localparam logic [1:0] OC_GND = 2'h2;
    // ======================================
    // Timing
    localparam int CLK_HZ = 125000000;
    localparam int SAMPLE_HZ = 8000;
    localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;
    localparam int INTERP_STEPS = 32;
    // ======================================
    // Types
    typedef enum logic [3:0] {
        DRV_NORM = 4'b0001,
        DRV_SUP = 4'b0010,
        DRV_GND = 4'b0100,
        DRV_TRI = 4'b1000
    } aoc_drive_t;
    typedef struct packed {
        logic [15:0] angle;
        logic [15:0] mag;
    } aoc_sample_t;
endpackage : aoc_pkg

// *** core/aoc_top.sv ***
// Angle output conditioning path with AXI4-Lite register slave
// Functional notes
// - 16-bit signed zero reference is subtracted first; origin for setpoints.
// - Magnitude outside field limits forces output to high clamp.
// - Field floor and ceiling limits are 16-bit signed values.
// - Fold option repeats angle in four 90 or three 120 degree segments.
// - 16-bit signed pre-shift is added to the angle.
// - Signed gain -64..64; unity maps full turn to full scale.
// - Signed offset spans -200%..200%; most negative code gives -200%.
// - Output limited between floor and ceiling clamp registers.
// - Interpolator makes 32 even steps per sample period.
// - Setup one bit 15 enables interpolator, else bypass.
// - Quiet IIR low-pass acts only on changes below threshold.
// - Setup one bit 13 picks temperature or magnitude for fast channel 2.
// - Setup one bit 12 picks PWM (0) or SENT (1) format.
// - Bits 9:8 set short response; supply/ground only locked and analog.
// - Bit 7 picks error band, or overvoltage code versus ground.
// - Bit 4 picks 4094 or zero words before first valid sample.
// - Bit 2 latches diagnosis bits until next reset or until bit 2 is cleared.
// - Bit 1 decides whether diagnostic errors show on output.
// - Bit 0 locks the configuration against writes.
// - Short detection armed only after lock and a later reset.
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
module aoc_top #(
    parameter int ADDR_W = 8,
    parameter int SAMPLE_CYCLES = aoc_pkg::SAMPLE_CYC,
    parameter bit ANALOG = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire aoc_pkg::aoc_sample_t samp,
    input wire logic samp_valid,
    input wire logic short_pin,
    input wire logic overvolt_pin,
    input wire logic nv_lock_pin,
    output logic [15:0] dac_value,
    output logic dac_strobe,
    output aoc_pkg::aoc_drive_t drive_state,
    output logic [11:0] sent_word,
    output logic sent_select,
    output logic fc2_magnitude
);
    localparam int TICK = SAMPLE_CYCLES / aoc_pkg::INTERP_STEPS;

    // Refuse settings the datapath cannot serve
    if (ADDR_W < 6 || TICK < 2) begin : g_bad_param
        $error("aoc_top: bad parameters");
    end

    // ======================================
    // Register bus state
    localparam int NCFG_W = 1;
    logic [NCFG_W-1:0] unused_w;
    logic [aoc_pkg::NCFG-1:0][15:0] cfg_q;
    logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q;
    logic arready_q, rvalid_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q, rdata_q;
    logic [3:0] wstrb_q;
    logic [1:0] bresp_q, rresp_q;

    // Decode
    wire [3:0] widx = awaddr_q[5:2];
    wire [3:0] ridx = araddr[5:2];
    wire whigh_ok = (awaddr_q >> 6) == '0;
    wire rhigh_ok = (araddr >> 6) == '0;
    wire whit = whigh_ok && (widx < 4'(aoc_pkg::NCFG));
    wire locked = cfg_q[aoc_pkg::IX_SET1][aoc_pkg::B_LOCK];
    wire do_wr = aw_full_q && w_full_q && !bvalid_q;
    wire wr_ok = do_wr && whit && !locked;
    wire [15:0] wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    assign unused_w = wdata_q[31];

    // Address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            bvalid_q <= 1'b0;
            bresp_q <= aoc_pkg::RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else begin
            if (awvalid && awready_q) begin
                aw_full_q <= 1'b1;
                awready_q <= 1'b0;
                awaddr_q <= awaddr;
            end
            if (wvalid && wready_q) begin
                w_full_q <= 1'b1;
                wready_q <= 1'b0;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            if (do_wr) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= wr_ok ? aoc_pkg::RESP_OKAY : aoc_pkg::RESP_SLVERR;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
                awready_q <= 1'b1;
                wready_q <= 1'b1;
            end
        end
    end

    // One flop bank per configuration word
    for (genvar i = 0; i < aoc_pkg::NCFG; i++) begin : g_cfg
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cfg_q[i] <= aoc_pkg::CFG_RST[i];
            end else if (wr_ok && widx == 4'(i)) begin
                cfg_q[i] <= (cfg_q[i] & ~wmask) | (wdata_q[15:0] & wmask);
            end
        end
    end

    // ======================================
    // Named views of configuration
    wire [15:0] set1 = cfg_q[aoc_pkg::IX_SET1];
    wire [15:0] fold = cfg_q[aoc_pkg::IX_FOLD];
    wire signed [15:0] olo = cfg_q[aoc_pkg::IX_OLO];
    wire signed [15:0] ohi = cfg_q[aoc_pkg::IX_OHI];
    wire signed [15:0] thr = cfg_q[aoc_pkg::IX_THR];
    wire signed [15:0] cut = cfg_q[aoc_pkg::IX_CUT];

    // ======================================
    // Sample datapath, fixed order
    logic signed [21:0] filt_q;
    wire [15:0] a_ref = samp.angle - cfg_q[aoc_pkg::IX_REF];
    wire [15:0] a_x3 = a_ref + {a_ref[14:0], 1'b0};
    wire [15:0] a_x4 = {a_ref[13:0], 2'b00};
    wire [15:0] a_fold = !fold[aoc_pkg::B_FOLD_EN] ? a_ref :
        fold[aoc_pkg::B_FOLD_120] ? a_x3 : a_x4;
    wire [15:0] a_pre = a_fold + cfg_q[aoc_pkg::IX_PRE];
    // Gain code 512 is unity; 16384 is full output
    wire signed [32:0] prod =
        $signed({1'b0, a_pre}) * $signed(cfg_q[aoc_pkg::IX_SCALE]);
    wire signed [21:0] scaled = prod[aoc_pkg::GAIN_SHIFT+21:aoc_pkg::GAIN_SHIFT];
    wire [15:0] shf = cfg_q[aoc_pkg::IX_SHIFT];
    wire signed [21:0] offs = scaled + $signed({{6{shf[15]}}, shf});

    // Quiet filter: small changes smoothed, steps pass at once
    wire signed [21:0] delta = offs - filt_q;
    wire [21:0] adelta = delta[21] ? 22'(-delta) : delta;
    wire [16:0] thr_mag = 17'(-$signed({thr[15], thr}));
    wire quiet = (thr != 16'sh0) && (adelta < {5'h0, thr_mag});
    wire signed [37:0] qprod = delta * cut;
    wire signed [21:0] qstep = qprod[aoc_pkg::QF_SHIFT+21:aoc_pkg::QF_SHIFT];
    wire signed [21:0] filt_d = quiet ? filt_q + qstep : offs;

    // Clamp and range check
    wire signed [21:0] lo22 = {{6{olo[15]}}, olo};
    wire signed [21:0] hi22 = {{6{ohi[15]}}, ohi};
    wire c_lo = filt_d < lo22;
    wire c_hi = filt_d > hi22;
    wire [15:0] clamped = c_lo ? olo : c_hi ? ohi : filt_d[15:0];
    wire signed [15:0] mag = samp.mag;
    wire f_lo = mag < $signed(cfg_q[aoc_pkg::IX_FLO]);
    wire f_hi = mag > $signed(cfg_q[aoc_pkg::IX_FHI]);
    wire [15:0] band = set1[aoc_pkg::B_EBAND] ? 16'h0000 : aoc_pkg::FULL_SCALE;
    wire show_err = set1[aoc_pkg::B_SHOW] && (c_lo || c_hi);
    wire [15:0] target_d = (f_lo || f_hi) ? ohi :
        show_err ? band : clamped;

    logic [15:0] target_q;
    logic tgt_new_q, seen_q;

    // Per-sample state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filt_q <= '0;
            target_q <= '0;
            tgt_new_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            tgt_new_q <= samp_valid;
            if (samp_valid) begin
                filt_q <= filt_d;
                target_q <= target_d;
                seen_q <= 1'b1;
            end
        end
    end

    // ======================================
    // Pin synchronisers and short detection arming
    logic [2:0] sync1_q, sync2_q;
    logic [1:0] cap_cnt_q;
    logic armed_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {nv_lock_pin, overvolt_pin, short_pin};
            sync2_q <= sync1_q;
        end
    end
    wire short_s = sync2_q[0];
    wire ovv_s = sync2_q[1];

    // Lock state is caught once, after release, so arming needs a fresh reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_cnt_q <= '0;
            armed_q <= 1'b0;
        end else if (cap_cnt_q != 2'h3) begin
            cap_cnt_q <= cap_cnt_q + 2'h1;
            if (cap_cnt_q == 2'h2) begin
                armed_q <= sync2_q[2];
            end
        end
    end

    // ======================================
    // Diagnosis status, optionally latched
    logic [5:0] stat_q;
    logic [3:0] sflag_q;
    wire [5:0] stat_cur = {armed_q, armed_q && short_s, sflag_q};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sflag_q <= '0;
            stat_q <= '0;
        end else begin
            if (samp_valid) begin
                sflag_q <= {c_hi, c_lo, f_hi, f_lo};
            end
            stat_q <= set1[aoc_pkg::B_LATCH] ? (stat_q | stat_cur) : stat_cur;
        end
    end

    // ======================================
    // Output drive state
    aoc_pkg::aoc_drive_t drv_q, drv_d;
    wire [1:0] oc_mode = set1[aoc_pkg::B_OC+1:aoc_pkg::B_OC];
    wire rail_ok = locked && ANALOG;
    always_comb begin
        drv_d = aoc_pkg::DRV_NORM;
        if (armed_q && short_s) begin
            case (oc_mode)
                aoc_pkg::OC_SUP: drv_d = rail_ok ? aoc_pkg::DRV_SUP : aoc_pkg::DRV_TRI;
                aoc_pkg::OC_GND: drv_d = rail_ok ? aoc_pkg::DRV_GND : aoc_pkg::DRV_TRI;
                default: drv_d = aoc_pkg::DRV_TRI;
            endcase
        end else if (!ANALOG && ovv_s && set1[aoc_pkg::B_EBAND]) begin
            drv_d = aoc_pkg::DRV_GND;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            drv_q <= aoc_pkg::DRV_NORM;
        end else begin
            drv_q <= drv_d;
        end
    end

    // ======================================
    // Interpolator toward the DAC
    logic [15:0] dac_q;
    logic strobe_q, run_q;
    logic signed [16:0] step_q;
    logic [4:0] k_q;
    logic [$clog2(TICK)-1:0] tcnt_q;
    wire signed [16:0] diff =
        $signed({target_q[15], target_q}) - $signed({dac_q[15], dac_q});
    wire tick = run_q && (tcnt_q == ($clog2(TICK))'(TICK - 1));
    wire last = k_q == 5'(aoc_pkg::INTERP_STEPS - 1);
    wire interp_en = set1[aoc_pkg::B_INTERP];

    // Exact target on the final step stops drift from truncated steps
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dac_q <= '0;
            strobe_q <= 1'b0;
            run_q <= 1'b0;
            step_q <= '0;
            k_q <= '0;
            tcnt_q <= '0;
        end else begin
            strobe_q <= 1'b0;
            tcnt_q <= tick ? '0 : tcnt_q + 1'b1;
            if (tgt_new_q && !interp_en) begin
                dac_q <= target_q;
                strobe_q <= 1'b1;
                run_q <= 1'b0;
            end else if (tgt_new_q) begin
                step_q <= diff >>> 5;
                k_q <= '0;
                tcnt_q <= '0;
                run_q <= 1'b1;
            end else if (tick) begin
                strobe_q <= 1'b1;
                k_q <= k_q + 5'h1;
                if (last) begin
                    dac_q <= target_q;
                    run_q <= 1'b0;
                end else begin
                    dac_q <= dac_q + step_q[15:0];
                end
            end
        end
    end

    // ======================================
    // Digital output word and selections
    logic [11:0] sent_q;
    logic sel_q, fc2_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sent_q <= '0;
            sel_q <= 1'b0;
            fc2_q <= 1'b0;
        end else begin
            sel_q <= set1[aoc_pkg::B_SENT];
            fc2_q <= set1[aoc_pkg::B_FC2];
            if (!seen_q) begin
                sent_q <= set1[aoc_pkg::B_START] ? 12'h000 : aoc_pkg::SENT_INIT;
            end else if (ovv_s && !set1[aoc_pkg::B_EBAND]) begin
                sent_q <= aoc_pkg::SENT_ERR;
            end else begin
                sent_q <= target_q[13:2];
            end
        end
    end

    // ======================================
    // Read channel
    wire [15:0] rd_word = (ridx < 4'(aoc_pkg::NCFG)) ? cfg_q[ridx] :
        (ridx == aoc_pkg::IX_STAT) ? {10'h0, stat_q} :
        (ridx == aoc_pkg::IX_OUT) ? dac_q : 16'h0;
    wire rhit = rhigh_ok && (ridx <= aoc_pkg::IX_OUT);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= aoc_pkg::RESP_OKAY;
        end else if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= {16'h0, rhit ? rd_word : 16'h0};
            rresp_q <= rhit ? aoc_pkg::RESP_OKAY : aoc_pkg::RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // Ports straight from flops
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign dac_value = dac_q;
    assign dac_strobe = strobe_q;
    assign drive_state = drv_q;
    assign sent_word = sent_q;
    assign sent_select = sel_q;
    assign fc2_magnitude = fc2_q;

    // ======================================
    // Checks
    sequence s_interp_start;
        tgt_new_q && interp_en;
    endsequence
    sequence s_last_tick;
        tick && last;
    endsequence

    chk_lock_refuse: assert property (@(posedge aclk) disable iff (!aresetn)
        do_wr && locked |=> bvalid && bresp == aoc_pkg::RESP_SLVERR)
        else $error("locked write not refused");
    chk_range_high: assert property (@(posedge aclk) disable iff (!aresetn)
        samp_valid && (f_lo || f_hi) |=> target_q == $past(ohi))
        else $error("range fault did not force high clamp");
    chk_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
        tgt_new_q && !interp_en |=> dac_value == $past(target_q) && dac_strobe)
        else $error("bypass did not pass target");
    chk_interp_start: assert property (@(posedge aclk) disable iff (!aresetn)
        s_interp_start |=> !dac_strobe [*2] ##0 run_q)
        else $error("interpolator did not start");
    chk_interp_end: assert property (@(posedge aclk) disable iff (!aresetn)
        s_last_tick and !tgt_new_q |=> dac_value == $past(target_q) && !run_q)
        else $error("final step missed target");
    chk_quiet_off: assert property (@(posedge aclk) disable iff (!aresetn)
        samp_valid && thr == 16'sh0 |=> filt_q == $past(offs))
        else $error("quiet filter active while disabled");
    chk_short_rail: assert property (@(posedge aclk) disable iff (!aresetn)
        armed_q && short_s && oc_mode == aoc_pkg::OC_SUP && rail_ok
        |=> drive_state == aoc_pkg::DRV_SUP)
        else $error("short response not supply");
    chk_short_unarmed: assert property (@(posedge aclk) disable iff (!aresetn)
        !armed_q && ANALOG |=> drive_state == aoc_pkg::DRV_NORM)
        else $error("short response while unarmed");
    chk_sent_start: assert property (@(posedge aclk) disable iff (!aresetn)
        !seen_q && !set1[aoc_pkg::B_START] ##1 !seen_q |-> sent_word == aoc_pkg::SENT_INIT)
        else $error("start-up word wrong");
    chk_diag_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        set1[aoc_pkg::B_LATCH] && stat_q[0] |=> stat_q[0])
        else $error("latched diagnosis dropped");
endmodule : aoc_top

// *** dv/aoc_dac_model.sv ***
// Output stage model: latches each converter update and counts them
`timescale 1ns/1ns
module aoc_dac_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] dac_value,
    input wire logic dac_strobe,
    output logic [15:0] level_q,
    output logic [31:0] updates_q
);
    // ======================================
    // Only strobed codes reach the pin; stale codes between strobes are ignored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_q <= 16'h0000;
            updates_q <= 32'h0;
        end else if (dac_strobe) begin
            level_q <= dac_value;
            updates_q <= updates_q + 32'h1;
        end
    end
endmodule : aoc_dac_model

// *** dv/angle_output_conditioning_bench.sv ***
// Self-checking bench for the angle output conditioning block
`timescale 1ns/1ns
module angle_output_conditioning_bench;
    localparam int SC = 320;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, samp_valid = 1'b0;
    logic short_pin = 1'b0, overvolt_pin = 1'b0, nv_lock_pin = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h3;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, dac_strobe, sent_select, fc2_magnitude;
    aoc_pkg::aoc_sample_t samp = '0;
    aoc_pkg::aoc_drive_t drive_state;
    logic [15:0] dac_value, level, d;
    logic [11:0] sent_word;
    logic [31:0] updates;
    int err_total = 0, cmp_count = 0, cyc = 0;
    // ======================================
    // Clock, watchdog and instances
    always #4 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc > 20000) begin
            err_total++;
            close_out();
        end
    end
    aoc_top #(.SAMPLE_CYCLES(SC)) dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .samp(samp),
        .samp_valid(samp_valid), .short_pin(short_pin), .overvolt_pin(overvolt_pin),
        .nv_lock_pin(nv_lock_pin), .dac_value(dac_value), .dac_strobe(dac_strobe),
        .drive_state(drive_state), .sent_word(sent_word), .sent_select(sent_select),
        .fc2_magnitude(fc2_magnitude));
    aoc_dac_model dac (.aclk(aclk), .aresetn(aresetn), .dac_value(dac_value),
        .dac_strobe(dac_strobe), .level_q(level), .updates_q(updates));
    // ======================================
    // Shared tasks
    task automatic close_out();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : close_out
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Reset held eight cycles; extra cycles let the lock pin synchroniser settle
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (5) @(posedge aclk);
    endtask : do_reset
    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [3:0] ix, input logic [15:0] v, output logic [1:0] rs);
        logic a;
        logic w;
        a = 1'b0;
        w = 1'b0;
        awaddr <= {2'h0, ix, 2'h0};
        wdata <= {16'h0000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(a && w)) begin
            @(posedge aclk);
            if (!a && awready) begin
                a = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge aclk); while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] ix, output logic [15:0] v, output logic [1:0] rs);
        araddr <= {2'h0, ix, 2'h0};
        arvalid <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(posedge aclk); while (!rvalid);
        v = rdata[15:0];
        rs = rresp;
        check("read high half", 32'h0, {rdata[31:16], 16'h0});
        rready <= 1'b0;
    endtask : rd
    // Unity gain is 0x0200 with an 11 bit shift, so a full turn spans 0x4000
    function automatic logic [15:0] calc(input logic [15:0] a, input logic [15:0] g,
                                         input logic [15:0] o);
        calc = 16'((32'(a) * 32'(g)) >> aoc_pkg::GAIN_SHIFT) + o;
    endfunction : calc
    // One sample, then a full sample period for the output to settle
    task automatic feed(input logic [15:0] ang, input logic [15:0] mg, input int steps,
                        input logic [15:0] ev);
        logic [31:0] n0;
        n0 = updates;
        samp <= {ang, mg};
        samp_valid <= 1'b1;
        @(posedge aclk);
        samp_valid <= 1'b0;
        repeat (SC + 20) @(posedge aclk);
        check("dac level", {16'h0, ev}, {16'h0, level});
        check("dac updates", 32'(steps), updates - n0);
    endtask : feed
    // ======================================
    // Main sequence
    initial begin
        do_reset();
        check("sent start", 32'(aoc_pkg::SENT_INIT), 32'(sent_word));
        for (int i = 0; i < aoc_pkg::NCFG; i++) begin
            rd(4'(i), d, r);
            check("reset value", {16'h0, aoc_pkg::CFG_RST[i]}, {16'h0, d});
        end
        rd(4'hf, d, r);
        check("unmapped read", 32'h2, {30'h0, r} | {16'h0, d});
        wr(4'hf, 16'h1234, r);
        check("unmapped write", 32'(aoc_pkg::RESP_SLVERR), 32'(r));
        rd(aoc_pkg::IX_STAT, d, r);
        check("not armed", 32'h0, 32'(d[aoc_pkg::ST_ARMED]));
        wr(aoc_pkg::IX_PRE, 16'ha5c3, r);
        rd(aoc_pkg::IX_PRE, d, r);
        check("preshift readback", 32'ha5c3, {16'h0, d});
        wr(aoc_pkg::IX_REF, 16'h1000, r);
        wr(aoc_pkg::IX_PRE, 16'h0800, r);
        wr(aoc_pkg::IX_SHIFT, 16'h0100, r);
        wr(aoc_pkg::IX_FLO, 16'h0100, r);
        feed(16'h4000, 16'h0150, 1, calc(16'h3800, 16'h0200, 16'h0100));
        wr(aoc_pkg::IX_SCALE, 16'h0400, r);
        feed(16'h4000, 16'h0150, 1, calc(16'h3800, 16'h0400, 16'h0100));
        wr(aoc_pkg::IX_OHI, 16'h3000, r);
        feed(16'h4000, 16'h0010, 1, 16'h3000);
        wr(aoc_pkg::IX_FHI, 16'h0200, r);
        feed(16'h4000, 16'h0150, 1, calc(16'h3800, 16'h0400, 16'h0100));
        feed(16'h4000, 16'h0400, 1, 16'h3000);
        wr(aoc_pkg::IX_OHI, 16'h1000, r);
        feed(16'h4000, 16'h0150, 1, 16'h1000);
        // Show errors, low band, latched diagnosis
        wr(aoc_pkg::IX_SET1, 16'h0086, r);
        feed(16'h4000, 16'h0010, 1, 16'h1000);
        feed(16'h4000, 16'h0150, 1, 16'h0000);
        rd(aoc_pkg::IX_STAT, d, r);
        check("latched status", 32'h9, 32'(d[3:0]));
        wr(aoc_pkg::IX_SET1, 16'h0000, r);
        wr(aoc_pkg::IX_OLO, 16'h0200, r);
        wr(aoc_pkg::IX_SHIFT, 16'h8000, r);
        feed(16'h4000, 16'h0150, 1, 16'h0200);
        wr(aoc_pkg::IX_REF, 16'h0000, r);
        wr(aoc_pkg::IX_PRE, 16'h0000, r);
        wr(aoc_pkg::IX_SCALE, 16'h0200, r);
        wr(aoc_pkg::IX_SHIFT, 16'h0000, r);
        wr(aoc_pkg::IX_OLO, 16'h0000, r);
        wr(aoc_pkg::IX_OHI, 16'h3fff, r);
        wr(aoc_pkg::IX_FOLD, 16'h0001, r);
        feed(16'h5000, 16'h0150, 1, calc(16'h4000, 16'h0200, 16'h0));
        wr(aoc_pkg::IX_FOLD, 16'h0003, r);
        feed(16'h5000, 16'h0150, 1, calc(16'hf000, 16'h0200, 16'h0));
        wr(aoc_pkg::IX_FOLD, 16'h0000, r);
        // Small change from 0x3c00 is smoothed by one sixteenth
        wr(aoc_pkg::IX_THR, 16'hff00, r);
        wr(aoc_pkg::IX_CUT, 16'h0800, r);
        feed(16'hf200, 16'h0150, 1, 16'h3c08);
        wr(aoc_pkg::IX_SET1, 16'hb000, r);
        feed(16'h8000, 16'h0150, 32, 16'h2000);
        check("sent word", 32'h800, 32'(sent_word));
        check("sent select", 32'h1, 32'(sent_select));
        check("fc2 magnitude", 32'h1, 32'(fc2_magnitude));
        nv_lock_pin <= 1'b1;
        do_reset();
        rd(aoc_pkg::IX_STAT, d, r);
        check("armed", 32'h1, 32'(d[aoc_pkg::ST_ARMED]));
        wr(aoc_pkg::IX_SET1, 16'h0101, r);
        short_pin <= 1'b1;
        for (int k = 0; k < 4000 && drive_state === aoc_pkg::DRV_NORM; k++) @(posedge aclk);
        check("short drive", 32'(aoc_pkg::DRV_SUP), 32'(drive_state));
        wr(aoc_pkg::IX_SCALE, 16'h0400, r);
        check("locked write", 32'(aoc_pkg::RESP_SLVERR), 32'(r));
        rd(aoc_pkg::IX_SCALE, d, r);
        check("locked value", 32'h0200, {16'h0, d});
        close_out();
    end
endmodule : angle_output_conditioning_bench
